// ==== src/lpi_device.sv ====
// device side of the double-data-rate pin interface: CA capture, decode, banks, data bursts
// assumes CK and CK# complementary, write strobe edges aligned with CK edges
`timescale 1ns/1ps
`default_nettype none

module lpi_device #(
    parameter int DQ_W = lpi_pkg::DQ_W_DEF,
    parameter int RL = lpi_pkg::RL_DEF,
    parameter int WL = lpi_pkg::WL_DEF,
    parameter int BL = lpi_pkg::BL_DEF,
    parameter int ROW_LO = lpi_pkg::ROW_LO_DEF,
    parameter int COL_LO = lpi_pkg::COL_LO_DEF
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ck_in,
    input wire logic ck_n_in,
    input wire logic cke_in,
    input wire logic cs_n_in,
    input wire logic [lpi_pkg::CA_W-1:0] ca_in,
    input wire logic [DQ_W-1:0] dq_in,
    output logic [DQ_W-1:0] dq_out,
    output logic dq_oe_out,
    input wire logic [DQ_W/8-1:0] dm_in,
    output logic [DQ_W/8-1:0] dqs_out,
    output logic [DQ_W/8-1:0] dqs_n_out,
    output logic dqs_oe_out,
    output logic [lpi_pkg::BANKS-1:0] bank_open_out,
    output logic power_down_out,
    output logic cmd_pulse_out
);

    // ------------------------------------------------------------------
    // shape
    // ------------------------------------------------------------------
    localparam int NB = DQ_W / lpi_pkg::BYTE_W;
    localparam int BLW = $clog2(BL);
    localparam int PAIRS = BL / 2;
    localparam int PW = $clog2(PAIRS + 1);
    localparam int CW = $clog2(RL + WL + 1);
    localparam int AW = lpi_pkg::BA_W + ROW_LO + COL_LO;
    localparam int DEPTH = 1 << AW;
    localparam int RD_DLY = RL - 1;
    localparam int BAW = lpi_pkg::BA_W;

    if (!(DQ_W == 16 || DQ_W == 32) || !(BL == 4 || BL == 8 || BL == 16) || RL < 3
        || WL < 2 || COL_LO < 4 || COL_LO >= lpi_pkg::COL_W || ROW_LO < 1
        || ROW_LO > lpi_pkg::ROW_W) begin : g_bad_cfg
        $error("lpi_device: unsupported parameter set");
    end

    // ------------------------------------------------------------------
    // link reset: asserted at once, released on a CK edge
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_link_q;

    always_ff @(posedge ck_in or posedge rst_in) begin
        if (rst_in) begin
            rst_meta_q <= lpi_pkg::RST_LINK_HOLD;
            rst_link_q <= lpi_pkg::RST_LINK_HOLD;
        end else begin
            rst_meta_q <= 1'b0;
            rst_link_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // negative-half capture
    // ------------------------------------------------------------------
    logic cke_q;
    logic [lpi_pkg::CA_W-1:0] ca_fall_q;
    logic [lpi_pkg::CA_W-1:0] ca_fall_d;
    logic [DQ_W-1:0] dq_fall_q;
    logic [DQ_W-1:0] dq_fall_d;
    logic [NB-1:0] dm_fall_q;
    logic [NB-1:0] dm_fall_d;

    // input buffers are off while clock enable is low
    always_comb begin
        ca_fall_d = cke_q ? ca_in : ca_fall_q;
        dq_fall_d = cke_q ? dq_in : dq_fall_q;
        dm_fall_d = cke_q ? dm_in : dm_fall_q;
    end

    // CK# rising marks the negative edge
    always_ff @(posedge ck_n_in or posedge rst_link_q) begin
        if (rst_link_q) begin
            ca_fall_q <= '0;
            dq_fall_q <= '0;
            dm_fall_q <= '0;
        end else begin
            ca_fall_q <= ca_fall_d;
            dq_fall_q <= dq_fall_d;
            dm_fall_q <= dm_fall_d;
        end
    end

    // ------------------------------------------------------------------
    // positive-half capture and command decode
    // ------------------------------------------------------------------
    logic cs_n_q;
    logic pd_q;
    logic cmd_tgl_q;
    logic cmd_tgl_d;
    logic [lpi_pkg::CA_W-1:0] ca_rise_q;
    logic [lpi_pkg::CA_W-1:0] ca_rise_d;
    logic cmd_ok;
    logic cmd_act;
    logic cmd_rd;
    logic cmd_wr;
    logic cmd_pre;
    logic [lpi_pkg::BA_W-1:0] cmd_bank;
    logic [lpi_pkg::ROW_W-1:0] act_row;
    logic [lpi_pkg::COL_W-1:0] cmd_col;

    always_comb begin
        ca_rise_d = cke_in ? ca_in : ca_rise_q;
        cmd_ok = !cs_n_q && cke_q && !pd_q;
        cmd_act = cmd_ok && ca_rise_q[1:0] == lpi_pkg::OP_ACT;
        cmd_rd = cmd_ok && ca_rise_q[2:0] == lpi_pkg::OP_RD;
        cmd_wr = cmd_ok && ca_rise_q[2:0] == lpi_pkg::OP_WR;
        cmd_pre = cmd_ok && ca_rise_q[3:0] == lpi_pkg::OP_PRE;
        cmd_bank = ca_rise_q[lpi_pkg::BANK_LSB +: lpi_pkg::BA_W];
        // both halves of one CA cycle form a single command
        act_row = {ca_rise_q[lpi_pkg::ROW_HI_LSB +: lpi_pkg::ROW_HI_W], ca_fall_q};
        cmd_col = {ca_fall_q[lpi_pkg::CA_W-1:lpi_pkg::COL_LSB], 1'b0};
        cmd_tgl_d = cmd_ok ? ~cmd_tgl_q : cmd_tgl_q;
    end

    always_ff @(posedge ck_in or posedge rst_link_q) begin
        if (rst_link_q) begin
            cke_q <= lpi_pkg::RST_CKE;
            cs_n_q <= lpi_pkg::RST_CS_N;
            pd_q <= 1'b1;
            ca_rise_q <= '0;
            cmd_tgl_q <= 1'b0;
        end else begin
            cke_q <= cke_in;
            cs_n_q <= cs_n_in;
            pd_q <= ~cke_q;
            ca_rise_q <= ca_rise_d;
            cmd_tgl_q <= cmd_tgl_d;
        end
    end

    // ------------------------------------------------------------------
    // banks
    // ------------------------------------------------------------------
    logic [lpi_pkg::BANKS-1:0] bank_open_w;
    logic [lpi_pkg::ROW_W-1:0] bank_row_w [lpi_pkg::BANKS];
    logic pre_all;

    assign pre_all = cmd_pre && ca_rise_q[lpi_pkg::PRE_ALL_BIT];

    for (genvar b = 0; b < lpi_pkg::BANKS; b++) begin : g_bank
        lpi_bank #(.ROW_W(lpi_pkg::ROW_W)) u_bank (
            .clk_in(ck_in),
            .rst_in(rst_link_q),
            .act_in(cmd_act && cmd_bank == BAW'(b)),
            .pre_in(pre_all || (cmd_pre && cmd_bank == BAW'(b))),
            .row_in(act_row),
            .open_out(bank_open_w[b]),
            .row_out(bank_row_w[b])
        );
    end

    // ------------------------------------------------------------------
    // array: only low row and column bits are kept to bound the model size
    // ------------------------------------------------------------------
    logic [DQ_W-1:0] mem [DEPTH];

    function automatic logic [AW-1:0] beat_addr(input logic [AW-1:0] base,
                                                input logic [BLW-1:0] k);
        beat_addr = {base[AW-1:BLW], base[BLW-1:0] + k};
    endfunction : beat_addr

    // ------------------------------------------------------------------
    // burst sequencer
    // ------------------------------------------------------------------
    lpi_pkg::lpi_burst_e st_q;
    lpi_pkg::lpi_burst_e st_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [PW-1:0] pair_q;
    logic [PW-1:0] pair_d;
    logic [AW-1:0] base_q;
    logic [AW-1:0] base_d;
    logic [AW-1:0] cmd_base;
    logic [3:0][DQ_W-1:0] pf_q;
    logic [3:0][DQ_W-1:0] pf_d;
    logic [DQ_W-1:0] out_rise_q;
    logic [DQ_W-1:0] out_rise_d;
    logic [DQ_W-1:0] out_fall_q;
    logic [DQ_W-1:0] out_fall_d;
    logic drive_q;
    logic drive_d;
    logic [DQ_W-1:0] wr_rise_q;
    logic [DQ_W-1:0] wr_rise_d;
    logic [NB-1:0] wr_dm_q;
    logic [NB-1:0] wr_dm_d;
    logic commit;
    logic [BLW-1:0] fetch_k;
    logic [AW-1:0] wr_a0;
    logic [AW-1:0] wr_a1;

    always_comb begin
        cmd_base = {cmd_bank, bank_row_w[cmd_bank][ROW_LO-1:0], cmd_col[COL_LO-1:0]};
        fetch_k = BLW'({pair_q + PW'(1), 1'b0});
        wr_a0 = beat_addr(base_q, BLW'({pair_q - PW'(1), 1'b0}));
        wr_a1 = beat_addr(base_q, BLW'({pair_q - PW'(1), 1'b1}));
        st_d = st_q;
        cnt_d = cnt_q;
        pair_d = pair_q;
        base_d = base_q;
        pf_d = pf_q;
        out_rise_d = out_rise_q;
        out_fall_d = out_fall_q;
        drive_d = 1'b0;
        wr_rise_d = wr_rise_q;
        wr_dm_d = wr_dm_q;
        commit = 1'b0;
        unique case (st_q)
            lpi_pkg::LPI_IDLE: begin
                // reads and writes arriving mid-burst are dropped
                if (cmd_rd) begin
                    st_d = lpi_pkg::LPI_RD_LAT;
                    cnt_d = CW'(RL - 3);
                    base_d = cmd_base;
                end else if (cmd_wr) begin
                    // first beat is caught one edge after entering the transfer state
                    base_d = cmd_base;
                    if (WL == 2) begin
                        st_d = lpi_pkg::LPI_WR_XFER;
                        pair_d = '0;
                    end else begin
                        st_d = lpi_pkg::LPI_WR_LAT;
                        cnt_d = CW'(WL - 3);
                    end
                end
            end
            lpi_pkg::LPI_RD_LAT: begin
                if (cnt_q == '0) begin
                    for (int j = 0; j < 4; j++) begin
                        pf_d[j] = mem[beat_addr(base_q, BLW'(j))];
                    end
                    pair_d = '0;
                    st_d = lpi_pkg::LPI_RD_XFER;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            lpi_pkg::LPI_RD_XFER: begin
                drive_d = 1'b1;
                out_rise_d = pair_q[0] ? pf_q[2] : pf_q[0];
                out_fall_d = pair_q[0] ? pf_q[3] : pf_q[1];
                if (pair_q == PW'(PAIRS - 1)) begin
                    st_d = lpi_pkg::LPI_IDLE;
                end else begin
                    pair_d = pair_q + PW'(1);
                    if (pair_q[0]) begin
                        for (int j = 0; j < 4; j++) begin
                            pf_d[j] = mem[beat_addr(base_q, fetch_k + BLW'(j))];
                        end
                    end
                end
            end
            lpi_pkg::LPI_WR_LAT: begin
                if (cnt_q == '0) begin
                    pair_d = '0;
                    st_d = lpi_pkg::LPI_WR_XFER;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            lpi_pkg::LPI_WR_XFER: begin
                commit = pair_q != '0;
                wr_rise_d = dq_in;
                wr_dm_d = dm_in;
                if (pair_q == PW'(PAIRS)) begin
                    st_d = lpi_pkg::LPI_IDLE;
                end else begin
                    pair_d = pair_q + PW'(1);
                end
            end
            default: begin
                st_d = lpi_pkg::LPI_IDLE;
            end
        endcase
    end

    always_ff @(posedge ck_in or posedge rst_link_q) begin
        if (rst_link_q) begin
            st_q <= lpi_pkg::LPI_IDLE;
            cnt_q <= '0;
            pair_q <= '0;
            base_q <= '0;
            pf_q <= '0;
            out_rise_q <= '0;
            out_fall_q <= '0;
            drive_q <= 1'b0;
            wr_rise_q <= '0;
            wr_dm_q <= '0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            pair_q <= pair_d;
            base_q <= base_d;
            pf_q <= pf_d;
            out_rise_q <= out_rise_d;
            out_fall_q <= out_fall_d;
            drive_q <= drive_d;
            wr_rise_q <= wr_rise_d;
            wr_dm_q <= wr_dm_d;
        end
    end

    // both beats of a pair land one edge after the falling beat is caught
    always_ff @(posedge ck_in) begin
        if (commit) begin
            for (int b = 0; b < NB; b++) begin
                if (!wr_dm_q[b]) begin
                    mem[wr_a0][b*8 +: 8] <= wr_rise_q[b*8 +: 8];
                end
                if (!dm_fall_q[b]) begin
                    mem[wr_a1][b*8 +: 8] <= dq_fall_q[b*8 +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // pins: beat multiplexed on CK level, strobe edge-aligned to the beats
    // ------------------------------------------------------------------
    assign dq_out = ck_in ? out_rise_q : out_fall_q;
    assign dq_oe_out = drive_q && cke_q;
    assign dqs_out = {NB{ck_in}};
    assign dqs_n_out = {NB{~ck_in}};
    assign dqs_oe_out = drive_q && cke_q;

    // ------------------------------------------------------------------
    // status into the system clock domain
    // ------------------------------------------------------------------
    logic [lpi_pkg::BANKS-1:0] open_meta_q;
    logic [lpi_pkg::BANKS-1:0] open_sync_q;
    logic pd_meta_q;
    logic pd_sync_q;
    logic tgl_meta_q;
    logic tgl_sync_q;
    logic tgl_old_q;
    logic pulse_q;
    logic pulse_d;

    assign pulse_d = tgl_sync_q ^ tgl_old_q;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            open_meta_q <= '0;
            open_sync_q <= '0;
            pd_meta_q <= 1'b1;
            pd_sync_q <= 1'b1;
            tgl_meta_q <= 1'b0;
            tgl_sync_q <= 1'b0;
            tgl_old_q <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            open_meta_q <= bank_open_w;
            open_sync_q <= open_meta_q;
            pd_meta_q <= pd_q;
            pd_sync_q <= pd_meta_q;
            tgl_meta_q <= cmd_tgl_q;
            tgl_sync_q <= tgl_meta_q;
            tgl_old_q <= tgl_sync_q;
            pulse_q <= pulse_d;
        end
    end

    assign bank_open_out = open_sync_q;
    assign power_down_out = pd_sync_q;
    assign cmd_pulse_out = pulse_q;

    // ------------------------------------------------------------------
    // checks on the link clock
    // ------------------------------------------------------------------
    default clocking cb_link @(posedge ck_in);
    endclocking
    default disable iff (rst_link_q);

    logic [PW:0] run_q;
    logic [AW-1:0] chk_addr_q;
    logic [7:0] chk_old_q;
    logic [7:0] chk_new_q;
    logic chk_mask_q;
    logic [lpi_pkg::BA_W-1:0] chk_bank_q;

    always_ff @(posedge ck_in) begin
        run_q <= drive_q ? run_q + (PW+1)'(1) : '0;
        chk_addr_q <= wr_a0;
        chk_old_q <= mem[wr_a0][7:0];
        chk_new_q <= wr_rise_q[7:0];
        chk_mask_q <= wr_dm_q[0];
        chk_bank_q <= cmd_bank;
    end

    logic [CW-1:0] rd_age_q;

    // link cycles since a read was taken, cleared if clock enable drops
    always_ff @(posedge ck_in or posedge rst_link_q) begin
        if (rst_link_q) begin
            rd_age_q <= '0;
        end else if (st_q == lpi_pkg::LPI_IDLE && cmd_rd) begin
            rd_age_q <= CW'(1);
        end else if (rd_age_q != '0 && rd_age_q != CW'(RL) && cke_q) begin
            rd_age_q <= rd_age_q + CW'(1);
        end else begin
            rd_age_q <= '0;
        end
    end

    sequence s_rd_due;
        rd_age_q == CW'(RL) && cke_q;
    endsequence

    sequence s_rd_data;
        dq_oe_out && dqs_oe_out;
    endsequence

    chk_rd_latency_exact: assert property (s_rd_due |-> s_rd_data)
        else $error("read data not on pins at read latency");
    chk_rd_not_early: assert property (rd_age_q == CW'(RD_DLY) |-> !dq_oe_out)
        else $error("read data on pins before read latency");
    chk_rd_burst_length: assert property ($fell(drive_q) |-> run_q == (PW+1)'(PAIRS))
        else $error("read burst beat pairs differ from burst length");
    chk_drive_only_read: assert property (dq_oe_out |-> $past(st_q) == lpi_pkg::LPI_RD_XFER)
        else $error("data pins driven outside a read burst");
    chk_cke_low_quiet: assert property (!cke_q |-> !dq_oe_out && !dqs_oe_out)
        else $error("outputs driven with clock enable low");
    chk_pd_enter: assert property ($fell(cke_q) |=> pd_q ##1 (pd_q || cke_q))
        else $error("power-down not entered on clock enable fall");
    chk_pd_exit_nop: assert property ($rose(cke_q) |-> !cmd_ok)
        else $error("command taken in power-down exit cycle");
    chk_cmd_needs_cs: assert property (st_q == lpi_pkg::LPI_IDLE && cs_n_q |=> st_q == lpi_pkg::LPI_IDLE)
        else $error("burst started without chip select");
    chk_mask_keeps: assert property (commit && wr_dm_q[0] |=> mem[chk_addr_q][7:0] == chk_old_q)
        else $error("masked byte was overwritten");
    chk_unmasked_writes: assert property (commit && !wr_dm_q[0] |=> mem[chk_addr_q][7:0] == chk_new_q)
        else $error("unmasked byte not written");
    chk_act_opens_bank: assert property (cmd_act |=> bank_open_w[chk_bank_q])
        else $error("activate did not open its bank");

endmodule : lpi_device

`default_nettype wire

// ==== src/lpi_pkg.sv ====
// constants, field positions and burst states shared by the pin-interface device
// assumes nothing beyond a SystemVerilog elaborator
package lpi_pkg;

    // ------------------------------------------------------------------
    // pin widths and array shape
    // ------------------------------------------------------------------
    localparam int CA_W = 10;
    localparam int BANKS = 8;
    localparam int BA_W = 3;
    localparam int ROW_W = 13;
    localparam int COL_W = 10;
    localparam int BYTE_W = 8;
    localparam int BANK_WORDS_X16 = 8388608;
    localparam int BANK_WORDS_X32 = 4194304;

    // ------------------------------------------------------------------
    // defaults for latency, burst and data width
    // ------------------------------------------------------------------
    localparam int DQ_W_DEF = 16;
    localparam int RL_DEF = 6;
    localparam int WL_DEF = 3;
    localparam int BL_DEF = 8;
    localparam int PREFETCH = 4;
    localparam int ROW_LO_DEF = 2;
    localparam int COL_LO_DEF = 5;

    // ------------------------------------------------------------------
    // command fields on the rising and falling halves of a CA cycle
    // ------------------------------------------------------------------
    localparam int BANK_LSB = 7;
    localparam int ROW_HI_LSB = 2;
    localparam int ROW_HI_W = 3;
    localparam int COL_LSB = 1;
    localparam int PRE_ALL_BIT = 4;
    localparam logic [1:0] OP_ACT = 2'h2;
    localparam logic [2:0] OP_WR = 3'h1;
    localparam logic [2:0] OP_RD = 3'h5;
    localparam logic [3:0] OP_PRE = 4'hb;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic RST_LINK_HOLD = 1'b1;
    localparam logic RST_CKE = 1'b0;
    localparam logic RST_CS_N = 1'b1;

    typedef enum logic [2:0] {
        LPI_IDLE = 3'h0,
        LPI_RD_LAT = 3'h1,
        LPI_RD_XFER = 3'h3,
        LPI_WR_LAT = 3'h4,
        LPI_WR_XFER = 3'h5
    } lpi_burst_e;

endpackage : lpi_pkg

// ==== src/lpi_bank.sv ====
// one bank's open-row tracker
// assumes activate and precharge strobes already decoded on the link clock
`timescale 1ns/1ps
`default_nettype none

module lpi_bank #(
    parameter int ROW_W = lpi_pkg::ROW_W
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic act_in,
    input wire logic pre_in,
    input wire logic [ROW_W-1:0] row_in,
    output logic open_out,
    output logic [ROW_W-1:0] row_out
);

    logic open_q;
    logic open_d;
    logic [ROW_W-1:0] row_q;
    logic [ROW_W-1:0] row_d;

    // activate wins over a same-cycle precharge of this bank
    always_comb begin
        open_d = open_q;
        row_d = row_q;
        if (act_in) begin
            open_d = 1'b1;
            row_d = row_in;
        end else if (pre_in) begin
            open_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            open_q <= 1'b0;
            row_q <= '0;
        end else begin
            open_q <= open_d;
            row_q <= row_d;
        end
    end

    assign open_out = open_q;
    assign row_out = row_q;

endmodule : lpi_bank

`default_nettype wire

// ==== tb/lpi_ctrl_model.sv ====
// controller model driving the link pins of the device
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ps
`default_nettype none
module lpi_ctrl_model (
    output logic ck_out,
    output logic ck_n_out,
    output logic cke_out,
    output logic cs_n_out,
    output logic [9:0] ca_out,
    output logic [15:0] dq_out,
    output logic [1:0] dm_out
);
    initial begin
        ck_out = 1'b0;
        cke_out = 1'b0;
        cs_n_out = 1'b1;
        ca_out = 10'h000;
        dq_out = 16'h0000;
        dm_out = 2'h0;
    end
    // free-running differential clock, 48 ns
    always #24 ck_out = ~ck_out;
    assign ck_n_out = ~ck_out;
    // ----------------------------------------
    // one command cycle, inputs centred on edges
    // ----------------------------------------
    task automatic cmd(input logic cs_n, input logic [9:0] rise, input logic [9:0] fall);
        @(negedge ck_out) #12;
        cs_n_out = cs_n;
        ca_out = rise;
        @(posedge ck_out) #12;
        cs_n_out = 1'b1;
        ca_out = fall;
    endtask : cmd
    task automatic set_cke(input logic v);
        @(negedge ck_out) #12;
        cke_out = v;
    endtask : set_cke
    task automatic wr(input logic [127:0] d, input logic [15:0] m);
        repeat (lpi_pkg::WL_DEF - 1) @(posedge ck_out);
        for (int k = 0; k < 8; k++) begin
            if (k % 2 == 0) @(negedge ck_out) #12;
            else @(posedge ck_out) #12;
            dq_out = d[16*k +: 16];
            dm_out = m[2*k +: 2];
        end
        // released bus: inverse so stale data cannot pass
        @(negedge ck_out) #12;
        dq_out = ~dq_out;
        dm_out = ~dm_out;
    endtask : wr
endmodule : lpi_ctrl_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// bench: write, masked write, read back, ignored commands, power-down
// assumes lpi_device with its default parameters
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys, rst, ck, ck_n, cke, cs_n, dq_oe, dqs_oe, pd, pulse;
    logic [9:0] ca;
    logic [15:0] dq_c, dq_d, dq_w;
    logic [1:0] dm, dqs, dqs_n;
    logic [7:0] bank_open;
    logic [15:0] exp_q[$];
    logic [15:0] mem[8];
    int fails = 0;
    int n_compared = 0;
    int n_cmd = 0;
    assign dq_w = dq_oe ? dq_d : dq_c;
    always #5 clk_sys = ~clk_sys;
    always @(negedge clk_sys) if (pulse === 1'b1) n_cmd++;
    lpi_ctrl_model i_ctl (.ck_out(ck), .ck_n_out(ck_n), .cke_out(cke), .cs_n_out(cs_n),
        .ca_out(ca), .dq_out(dq_c), .dm_out(dm));
    lpi_device i_dut (.clk_sys_in(clk_sys), .rst_in(rst), .ck_in(ck), .ck_n_in(ck_n),
        .cke_in(cke), .cs_n_in(cs_n), .ca_in(ca), .dq_in(dq_w), .dq_out(dq_d),
        .dq_oe_out(dq_oe), .dm_in(dm), .dqs_out(dqs), .dqs_n_out(dqs_n),
        .dqs_oe_out(dqs_oe), .bank_open_out(bank_open), .power_down_out(pd),
        .cmd_pulse_out(pulse));
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic finish_test();
        if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    task automatic wait_st(input string nm, input logic [7:0] e, input logic sel);
        int i;
        for (i = 0; i < 60; i++) begin
            if ((sel ? {7'h00, pd} : bank_open) === e) break;
            @(posedge clk_sys);
        end
        check(nm, {8'h00, e}, {8'h00, sel ? {7'h00, pd} : bank_open});
        if (i == 60) begin
            fails++;
            finish_test();
        end
    endtask : wait_st
    // ----------------------------------------
    // read monitor: each driven half-beat takes the oldest note
    // ----------------------------------------
    always @(ck) begin
        #2;
        if (dq_oe === 1'b1) begin
            check("dqs", {14'h0000, ck, ck}, {14'h0000, dqs});
            check("dqs_oe", 16'h0001, {15'h0000, dqs_oe});
            if (exp_q.size() == 0) check("stray oe", 16'h0000, {15'h0000, dq_oe});
            else check("dq", exp_q.pop_front(), dq_d);
        end
    end
    initial begin
        logic [127:0] d, e;
        logic [15:0] m;
        logic [2:0] b;
        int i;
        clk_sys = 1'b0;
        rst = 1'b1;
        void'($urandom(54766));
        d = {$urandom, $urandom, $urandom, $urandom};
        e = {$urandom, $urandom, $urandom, $urandom};
        m = 16'($urandom);
        b = 3'($urandom);
        repeat (3) @(posedge ck);
        check("reset oe", 16'h0000, {15'h0000, dq_oe});
        @(posedge clk_sys) rst <= 1'b0;
        repeat (4) @(posedge ck);
        i_ctl.set_cke(1'b1);
        wait_st("pd exit", 8'h00, 1'b1);
        repeat (2) @(posedge ck);
        i_ctl.cmd(1'b0, {b, 5'h00, 2'h2}, 10'h000);
        wait_st("bank open", 8'h01 << b, 1'b0);
        i_ctl.cmd(1'b0, {b, 4'h0, 3'h1}, 10'h000);
        i_ctl.wr(d, 16'h0000);
        i_ctl.cmd(1'b0, {b, 4'h0, 3'h1}, 10'h000);
        i_ctl.wr(e, m);
        for (int k = 0; k < 16; k++) begin
            mem[k/2][8*(k%2) +: 8] = m[k] ? d[8*k +: 8] : e[8*k +: 8];
        end
        for (int k = 0; k < 8; k++) exp_q.push_back(mem[k]);
        i_ctl.cmd(1'b0, {b, 4'h0, 3'h5}, 10'h000);
        for (i = 0; i < 40 && exp_q.size() != 0; i++) @(posedge ck);
        check("beats left", 16'h0000, 16'(exp_q.size()));
        i_ctl.cmd(1'b1, {b, 4'h0, 3'h5}, 10'h000);
        repeat (12) @(posedge ck);
        i_ctl.cmd(1'b0, 10'h01b, 10'h000);
        wait_st("bank closed", 8'h00, 1'b0);
        i_ctl.set_cke(1'b0);
        wait_st("pd entry", 8'h01, 1'b1);
        i_ctl.cmd(1'b0, {b, 4'h0, 3'h5}, 10'h000);
        repeat (12) @(posedge ck);
        check("commands", 16'h0005, 16'(n_cmd));
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
